// ==== shared/pack_pkg.sv ====
// Package of constants and carriers for the part acknowledgement signalling.
package pack_pkg;

	// ****************************************************************
	// Timing and ranges.
	// ****************************************************************
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned FLASH_HALF_MS   = 250;
	localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / 1000 * FLASH_HALF_MS;
	localparam int unsigned PWM_STEPS       = 10;
	localparam int unsigned PWM_SLOT_CYC    = 1250;
	localparam logic [3:0]  VOL_MAX         = 4'hA;
	localparam logic [6:0]  STATION_MIN     = 7'h01;
	localparam logic [6:0]  STATION_MAX     = 7'h7E;
	localparam logic [6:0]  STATION_RST     = 7'h01;
	localparam int unsigned SEL_W           = 6;
	localparam int unsigned N_OUT           = 23;

	// ****************************************************************
	// Tri-state option settings.
	// ****************************************************************
	typedef enum logic [1:0]
	{
		PACK_OPT_UNSET = 2'b00,
		PACK_OPT_OFF   = 2'b01,
		PACK_OPT_ON    = 2'b10
	} pack_opt_t;

	// ****************************************************************
	// Carriers.
	// ****************************************************************
	typedef struct packed
	{
		logic       ack_enable;
		pack_opt_t  ack_ok_opt;
		pack_opt_t  ack_nok_opt;
		logic       ack_use_plc;
		logic       lock_on_nok;
		logic [3:0] volume;
		logic       ctrl_from_plc;
	} pack_cfg_t;

	typedef struct packed
	{
		logic       done;
		logic       ok;
		logic       strobe;
		logic [6:0] prog;
		logic [5:0] math_fail;
		logic [1:0] curve_pass;
		logic [1:0] curve_fail;
		logic [7:0] misc;
	} pack_result_t;

	typedef struct packed
	{
		logic ok_ack;
		logic nok_ack;
	} pack_ack_t;

endpackage

// ==== rtl/pack_buzzer_pwm.sv ====
// PWM generator that scales buzzer duty with a 0 to 10 volume.
module pack_buzzer_pwm
(
	// Clock and reset.
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	// Control.
	input  wire logic       i_sound,
	input  wire logic [3:0] i_volume,
	// Output.
	output logic            o_pwm
);

	logic [10:0] slot_reg;
	logic [10:0] slot_next;
	logic [3:0]  step_reg;
	logic [3:0]  step_next;
	logic        pwm_reg;
	logic        pwm_next;
	logic [3:0]  vol_sat;

	// ****************************************************************
	// Ten slots per period; volume slots are high.
	// ****************************************************************
	always_comb
	begin
		vol_sat   = (i_volume > pack_pkg::VOL_MAX) ? pack_pkg::VOL_MAX
			: i_volume;
		slot_next = slot_reg + 11'h001;
		step_next = step_reg;
		if (slot_reg == 11'(pack_pkg::PWM_SLOT_CYC - 1))
		begin
			slot_next = 11'h000;
			step_next = (step_reg == 4'(pack_pkg::PWM_STEPS - 1)) ? 4'h0
				: step_reg + 4'h1;
		end
		pwm_next = i_sound && (step_next < vol_sat);
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			slot_reg <= 11'h000;
			step_reg <= 4'h0;
			pwm_reg  <= 1'b0;
		end
		else
		begin
			slot_reg <= slot_next;
			step_reg <= step_next;
			pwm_reg  <= pwm_next;
		end
	end

	assign o_pwm = pwm_reg;

	a_pwm_silent: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_volume == 4'h0) |=> !o_pwm) else $error("buzzer on at zero");

endmodule

// ==== rtl/pack_ack_signal.sv ====
module pack_ack_signal
#(
	parameter int unsigned FLASH_HALF = pack_pkg::FLASH_HALF_CYC,
	parameter int unsigned N          = pack_pkg::N_OUT
)
(
	// Clock and reset.
	input  wire logic                     i_mclk,
	input  wire logic                     i_resetn,
	// Configuration.
	input  wire pack_pkg::pack_cfg_t      i_cfg,
	input  wire logic [6:0]               i_station_addr,
	input  wire logic                     i_station_wr,
	input  wire logic [N*pack_pkg::SEL_W-1:0] i_out_sel,
	// Measurement results, same clock.
	input  wire pack_pkg::pack_result_t   i_result,
	// Acknowledge sources.
	input  wire pack_pkg::pack_ack_t      i_plc_ack,
	input  wire pack_pkg::pack_ack_t      i_bus_ack,
	// Cyclic fieldbus data.
	input  wire logic                     i_bus_cycle,
	output logic [15:0]                   o_bus_data,
	// Outputs.
	output logic                          o_ok_confirm_lamp,
	output logic                          o_nok_confirm_lamp,
	output logic                          o_travel_lock_out,
	output logic                          o_ack_alarm_out,
	output logic                          o_buzzer_drive,
	output logic [6:0]                    o_station_addr,
	output logic [N-1:0]                  o_plc_out
);

	// ****************************************************************
	// Reset release and input synchronisers.
	// ****************************************************************
	logic       rst_s1_reg;
	logic       rst_n;
	logic [3:0] ack_s1_reg;
	logic [3:0] ack_s2_reg;
	logic [1:0] ack_prev_reg;

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_s1_reg <= 4'h0;
			ack_s2_reg <= 4'h0;
		end
		else
		begin
			ack_s1_reg <= {i_plc_ack, i_bus_ack};
			ack_s2_reg <= ack_s1_reg;
		end
	end

	// ****************************************************************
	// Acknowledge selection and edge detection.
	// ****************************************************************
	logic       ok_en;
	logic       nok_en;
	logic [1:0] ack_lvl;
	logic [1:0] ack_rise;

	always_comb
	begin
		ok_en  = i_cfg.ack_enable
			&& (i_cfg.ack_ok_opt == pack_pkg::PACK_OPT_ON);
		nok_en = i_cfg.ack_enable
			&& (i_cfg.ack_nok_opt == pack_pkg::PACK_OPT_ON);
		// Only the selected source can acknowledge.
		ack_lvl = i_cfg.ctrl_from_plc ? ack_s2_reg[3:2]
			: ack_s2_reg[1:0];
		if (i_cfg.ctrl_from_plc && !i_cfg.ack_use_plc)
			ack_lvl = 2'b00;
		ack_rise = ack_lvl & ~ack_prev_reg;
	end

	// ****************************************************************
	// Pending part state and lamps.
	// ****************************************************************
	typedef enum logic [1:0]
	{
		PACK_IDLE    = 2'b00,
		PACK_WAIT_OK = 2'b01,
		PACK_WAIT_NK = 2'b10
	} pack_state_t;

	pack_state_t state_reg;
	pack_state_t state_next;
	logic [23:0] flash_cnt_reg;
	logic [23:0] flash_cnt_next;
	logic        flash_reg;
	logic        flash_next;
	logic        alarm_reg;
	logic        alarm_next;
	logic        lock_reg;
	logic        lock_next;

	always_comb
	begin
		state_next     = state_reg;
		alarm_next     = alarm_reg;
		lock_next      = lock_reg;
		flash_cnt_next = flash_cnt_reg + 24'h000001;
		flash_next     = flash_reg;
		if (flash_cnt_reg == 24'(FLASH_HALF - 1))
		begin
			flash_cnt_next = 24'h000000;
			flash_next     = !flash_reg;
		end
		unique case (state_reg)
			PACK_IDLE:
				;
			PACK_WAIT_OK:
			begin
				if (ack_rise[1])
					state_next = PACK_IDLE;
				if (ack_rise[0])
					alarm_next = 1'b1;
			end
			PACK_WAIT_NK:
			begin
				if (ack_rise[0])
				begin
					state_next = PACK_IDLE;
					lock_next  = 1'b0;
				end
				if (ack_rise[1])
					alarm_next = 1'b1;
			end
			default:
				state_next = PACK_IDLE;
		endcase
		if (state_next == PACK_IDLE)
			alarm_next = 1'b0;
		if (i_result.done)
		begin
			alarm_next     = 1'b0;
			flash_cnt_next = 24'h000000;
			flash_next     = 1'b1;
			if (i_result.ok)
				state_next = ok_en ? PACK_WAIT_OK : PACK_IDLE;
			else
				state_next = nok_en ? PACK_WAIT_NK : PACK_IDLE;
			lock_next = !i_result.ok && i_cfg.lock_on_nok;
		end
		if (!i_cfg.ack_enable && !i_result.done && !lock_reg)
			state_next = PACK_IDLE;
	end

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg     <= PACK_IDLE;
			flash_cnt_reg <= 24'h000000;
			flash_reg     <= 1'b0;
			alarm_reg     <= 1'b0;
			lock_reg      <= 1'b0;
			ack_prev_reg  <= 2'b00;
		end
		else
		begin
			state_reg     <= state_next;
			flash_cnt_reg <= flash_cnt_next;
			flash_reg     <= flash_next;
			alarm_reg     <= alarm_next;
			lock_reg      <= lock_next;
			ack_prev_reg  <= ack_lvl;
		end
	end

	// Lock follows a NOK result in the same cycle as it is reported.
	assign o_travel_lock_out  = lock_reg
		|| (i_result.done && !i_result.ok && i_cfg.lock_on_nok);
	assign o_ok_confirm_lamp  = (state_reg == PACK_WAIT_OK) && flash_reg;
	assign o_nok_confirm_lamp = (state_reg == PACK_WAIT_NK) && flash_reg;
	assign o_ack_alarm_out    = alarm_reg;

	a_lamp_clears: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(state_reg == PACK_WAIT_OK && ack_rise == 2'b10 && !i_result.done)
		|=> !o_ok_confirm_lamp) else $error("ok lamp not cleared");
	a_alarm_wrong: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(state_reg == PACK_WAIT_NK && ack_rise == 2'b10 && !i_result.done)
		|=> o_ack_alarm_out) else $error("wrong ack no alarm");
	a_nok_flash: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_result.done && !i_result.ok && nok_en)
		|=> o_nok_confirm_lamp) else $error("nok lamp not lit");
	a_ok_flash: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_result.done && i_result.ok && ok_en)
		|=> o_ok_confirm_lamp) else $error("ok lamp not lit");
	a_unset_off: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_result.done && i_cfg.ack_ok_opt == pack_pkg::PACK_OPT_UNSET
		&& i_result.ok) |=> !o_ok_confirm_lamp)
		else $error("unset option acted");
	a_lock_now: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_result.done && !i_result.ok && i_cfg.lock_on_nok)
		|-> o_travel_lock_out) else $error("lock late");

	// ****************************************************************
	// Buzzer sounds while a part waits or alarm is set.
	// ****************************************************************
	pack_buzzer_pwm u_buzzer
	(
		.i_mclk   (i_mclk),
		.i_rst_n  (rst_n),
		.i_sound  (alarm_reg || (state_reg != PACK_IDLE)),
		.i_volume (i_cfg.volume),
		.o_pwm    (o_buzzer_drive)
	);

	// ****************************************************************
	// Station address holds only legal values.
	// ****************************************************************
	logic [6:0] station_reg;

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			station_reg <= pack_pkg::STATION_RST;
		else if (i_station_wr && i_station_addr >= pack_pkg::STATION_MIN
			&& i_station_addr <= pack_pkg::STATION_MAX)
			station_reg <= i_station_addr;
	end

	assign o_station_addr = station_reg;

	a_station_range: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_station_wr && i_station_addr > pack_pkg::STATION_MAX)
		|=> $stable(o_station_addr)) else $error("bad address taken");

	// ****************************************************************
	// Cyclic bus data always carries status and echo.
	// ****************************************************************
	logic [15:0] bus_data_reg;

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			bus_data_reg <= 16'h0000;
		else if (i_bus_cycle)
			bus_data_reg <= {o_ack_alarm_out, o_travel_lock_out,
				o_nok_confirm_lamp, o_ok_confirm_lamp, i_result.ok,
				i_result.strobe, 3'h0, i_result.prog};
	end

	assign o_bus_data = bus_data_reg;

	// ****************************************************************
	// Output selectors over every assignable signal.
	// ****************************************************************
	logic [63:0] sig_pool;

	always_comb
	begin
		sig_pool = {34'h0, o_ack_alarm_out, o_travel_lock_out,
			o_ok_confirm_lamp, o_nok_confirm_lamp,
			i_result.curve_pass, i_result.curve_fail,
			i_result.math_fail,
			i_result.prog, i_result.strobe,
			i_result.misc};
	end

	logic [N-1:0] plc_out_reg;

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			plc_out_reg <= '0;
		else
			for (int k = 0; k < N; k++)
				plc_out_reg[k] <= sig_pool[i_out_sel[k*6 +: 6]];
	end

	assign o_plc_out = plc_out_reg;

endmodule

// ==== tb/pack_plc_model.sv ====
// Model of the machine controller that raises acknowledge pins on request.
module pack_plc_model
#(
	parameter int unsigned HOLD = 4
)
(
	// Clock.
	input  wire logic           i_mclk,
	// Requests from the bench.
	input  wire logic           i_ok_req,
	input  wire logic           i_nok_req,
	// Acknowledge pins.
	output pack_pkg::pack_ack_t o_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	pack_pkg::pack_ack_t ack_reg = '0;
	int                  cnt = 0;

	assign o_ack = ack_reg;

	// The pin is held long enough to pass the two-stage synchroniser.
	always @(posedge i_mclk)
	begin
		if (i_ok_req || i_nok_req)
		begin
			ack_reg.ok_ack <= i_ok_req;
			ack_reg.nok_ack <= i_nok_req;
			cnt <= HOLD;
		end
		else if (cnt > 1)
			cnt <= cnt - 1;
		else
		begin
			ack_reg <= '0;
			cnt <= 0;
		end
	end
endmodule

// ==== tb/test_pack_ack_signal.sv ====
// Self-checking bench for the part acknowledgement signalling block.
`define CHK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
		end \
	end

module test_pack_ack_signal;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned FH = 4;
	localparam int unsigned NO = pack_pkg::N_OUT;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	pack_pkg::pack_cfg_t    cfg;
	pack_pkg::pack_result_t res;
	logic [6:0]             st_addr;
	logic                   st_wr;
	logic [NO*6-1:0]        sel;
	logic                   bus_cyc;
	logic                   pok, pnok, bok, bnok;
	pack_pkg::pack_ack_t    plc_ack, bus_ack;
	logic [15:0]            bus_data;
	logic                   ok_l, nok_l, lock, alarm, buzz;
	logic [6:0]             st_out;
	logic [NO-1:0]          plc_out;
	int                     err_total = 0;
	int                     check_count = 0;

	always #20 clk = ~clk;

	pack_ack_signal #(.FLASH_HALF(FH)) i_dut
	(
		.i_mclk(clk), .i_resetn(rst_n), .i_cfg(cfg),
		.i_station_addr(st_addr), .i_station_wr(st_wr),
		.i_out_sel(sel), .i_result(res), .i_plc_ack(plc_ack),
		.i_bus_ack(bus_ack), .i_bus_cycle(bus_cyc),
		.o_bus_data(bus_data), .o_ok_confirm_lamp(ok_l),
		.o_nok_confirm_lamp(nok_l), .o_travel_lock_out(lock),
		.o_ack_alarm_out(alarm), .o_buzzer_drive(buzz),
		.o_station_addr(st_out), .o_plc_out(plc_out)
	);
	pack_plc_model i_plc
	(
		.i_mclk(clk), .i_ok_req(pok), .i_nok_req(pnok), .o_ack(plc_ack)
	);
	pack_plc_model i_bus
	(
		.i_mclk(clk), .i_ok_req(bok), .i_nok_req(bnok), .o_ack(bus_ack)
	);

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic done_pulse(input logic ok);
		res.done = 1'b1;
		res.ok = ok;
		cyc(1);
		res.done = 1'b0;
	endtask

	// Requests one acknowledge and waits out synchroniser and edge detect.
	task automatic ack(input bit plc, input bit ok);
		if (plc)
			{pok, pnok} = {ok, !ok};
		else
			{bok, bnok} = {ok, !ok};
		cyc(1);
		{pok, pnok, bok, bnok} = '0;
		cyc(6);
	endtask

	// A flashing lamp is seen high in one of two samples a phase apart.
	task automatic seen(input bit nok, output logic f);
		logic a;
		a = nok ? nok_l : ok_l;
		cyc(FH);
		f = a | (nok ? nok_l : ok_l);
	endtask

	task automatic t_ok();
		logic f;
		cfg.ctrl_from_plc = 1'b1;
		done_pulse(1'b1);
		cyc(2);
		`CHK(ok_l, 1'b1)
		cyc(4);
		`CHK(ok_l, 1'b0)
		ack(1'b0, 1'b1);
		seen(1'b0, f);
		`CHK(f, 1'b1)
		cfg.ack_use_plc = 1'b0;
		ack(1'b1, 1'b1);
		seen(1'b0, f);
		`CHK(f, 1'b1)
		cfg.ack_use_plc = 1'b1;
		ack(1'b1, 1'b1);
		seen(1'b0, f);
		`CHK(f, 1'b0)
		`CHK(alarm, 1'b0)
		$display("test ok_flash finished");
	endtask

	task automatic t_nok();
		logic f;
		cfg.ctrl_from_plc = 1'b0;
		res.done = 1'b1;
		res.ok = 1'b0;
		#1;
		`CHK(lock, 1'b1)
		cyc(1);
		res.done = 1'b0;
		cyc(2);
		`CHK(nok_l, 1'b1)
		ack(1'b1, 1'b0);
		seen(1'b1, f);
		`CHK(f, 1'b1)
		ack(1'b0, 1'b1);
		`CHK(alarm, 1'b1)
		`CHK(lock, 1'b1)
		ack(1'b0, 1'b0);
		seen(1'b1, f);
		`CHK(f, 1'b0)
		`CHK({alarm, lock}, 2'b00)
		$display("test nok_lock finished");
	endtask

	task automatic t_unset();
		logic f;
		cfg.ack_ok_opt = pack_pkg::PACK_OPT_UNSET;
		cfg.ack_nok_opt = pack_pkg::PACK_OPT_UNSET;
		done_pulse(1'b1);
		cyc(1);
		seen(1'b0, f);
		`CHK(f, 1'b0)
		done_pulse(1'b0);
		cyc(1);
		seen(1'b1, f);
		`CHK(f, 1'b0)
		cfg.ack_ok_opt = pack_pkg::PACK_OPT_ON;
		cfg.ack_nok_opt = pack_pkg::PACK_OPT_ON;
		done_pulse(1'b1);
		ack(1'b0, 1'b1);
		$display("test unset_options finished");
	endtask

	task automatic t_station();
		logic [6:0] tab [4] = '{7'h00, 7'h7E, 7'h7F, 7'h01};
		logic [6:0] exp;
		exp = pack_pkg::STATION_RST;
		foreach (tab[i])
		begin
			st_addr = tab[i];
			st_wr = 1'b1;
			cyc(1);
			st_wr = 1'b0;
			cyc(2);
			if (tab[i] >= 7'h01 && tab[i] <= 7'h7E)
				exp = tab[i];
			`CHK(st_out, exp)
		end
		$display("test station finished");
	endtask

	task automatic t_buzz();
		int vols [3] = '{0, 5, 10};
		int n;
		foreach (vols[i])
		begin
			cfg.volume = 4'(vols[i]);
			done_pulse(1'b0);
			n = 0;
			repeat (12500)
			begin
				cyc(1);
				// An unknown level counts as a gross miss.
				n += (buzz === 1'b1) ? 1 : ((buzz === 1'b0) ? 0 : 20000);
			end
			`CHK(n, vols[i] * 1250)
		end
		ack(1'b0, 1'b0);
		n = 0;
		repeat (1250)
		begin
			cyc(1);
			n += (buzz === 1'b1) ? 1 : ((buzz === 1'b0) ? 0 : 20000);
		end
		`CHK(n, 0)
		$display("test buzzer finished");
	endtask

	task automatic t_sel();
		cfg.ctrl_from_plc = 1'b1;
		sel = '0;
		sel[35:0] = {6'd25, 6'd22, 6'd21, 6'd16, 6'd15, 6'd14};
		res.prog = 7'h60;
		res.math_fail = 6'h21;
		res.curve_fail = 2'h1;
		res.curve_pass = 2'h2;
		cyc(3);
		`CHK(plc_out[5:0], 6'h3F)
		bus_cyc = 1'b1;
		cyc(1);
		bus_cyc = 1'b0;
		`CHK(bus_data[6:0], 7'h60)
		res.prog = 7'h00;
		res.math_fail = 6'h00;
		res.curve_fail = 2'h0;
		res.curve_pass = 2'h0;
		cyc(3);
		`CHK(plc_out[5:0], 6'h00)
		`CHK(bus_data[6:0], 7'h60)
		$display("test selector finished");
	endtask

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		err_total++;
		stop_test();
	end

	initial
	begin
		cfg = '{1'b1, pack_pkg::PACK_OPT_ON, pack_pkg::PACK_OPT_ON,
			1'b1, 1'b1, 4'h5, 1'b1};
		res = '0;
		{st_addr, st_wr, bus_cyc} = '0;
		sel = '0;
		{pok, pnok, bok, bnok} = '0;
		cyc(10);
		rst_n = 1'b1;
		cyc(5);
		`CHK(st_out, pack_pkg::STATION_RST)
		`CHK({ok_l, nok_l, alarm}, 3'b000)
		t_ok();
		t_nok();
		t_unset();
		t_station();
		t_buzz();
		t_sel();
		stop_test();
	end
endmodule
